// File: rtl/icr_pkg.sv
// package: constants and carriers for the indexed configuration register bank
package icr_pkg;
  // i/o port addresses decoded under config select
  localparam logic [7:0] ICR_PORT_INDEX   = 8'h22;
  localparam logic [7:0] ICR_PORT_DATA    = 8'h23;
  localparam logic [7:0] ICR_PORT_DIRECT  = 8'h92;
  // register indices
  localparam logic [7:0] ICR_IDX_REV      = 8'h04;
  localparam logic [7:0] ICR_IDX_CMD_DLY  = 8'h05;
  localparam logic [7:0] ICR_IDX_WAIT     = 8'h06;
  localparam logic [7:0] ICR_IDX_CLK_SRC  = 8'h07;
  localparam logic [7:0] ICR_IDX_PORT_EN  = 8'h2b;
  localparam logic [7:0] ICR_IDX_NC_FIRST = 8'h30;
  localparam logic [7:0] ICR_IDX_NC_LAST  = 8'h39;
  localparam int         ICR_NC_REGS      = 10;
  // field layout
  localparam int         ICR_PORT_EN_BIT  = 6;
  localparam int         ICR_HOLD_BIT     = 1;
  localparam int         ICR_M16_LSB      = 4;
  localparam int         ICR_M8_LSB       = 2;
  localparam int         ICR_IO_LSB       = 0;
  localparam int         ICR_SRC_LSB      = 0;
  localparam logic [7:0] ICR_MASK_CMD_DLY = 8'h3f;
  localparam logic [7:0] ICR_MASK_WAIT    = 8'h3e;
  localparam logic [7:0] ICR_MASK_CLK_SRC = 8'h07;
  localparam logic [7:0] ICR_MASK_REV     = 8'h0f;
  // reset values
  localparam logic [7:0] ICR_RST_CMD_DLY  = 8'h00;
  localparam logic [7:0] ICR_RST_WAIT     = 8'h00;
  localparam logic [7:0] ICR_RST_CLK_SRC  = 8'h00;
  localparam logic [7:0] ICR_RST_PORT_EN  = 8'h40;
  localparam logic [7:0] ICR_RST_DIRECT   = 8'h00;
  // clock source codes
  localparam logic [2:0] ICR_SRC_DIV5     = 3'h0;
  localparam logic [2:0] ICR_SRC_DIV4     = 3'h1;
  localparam logic [2:0] ICR_SRC_DIV3     = 3'h2;
  localparam logic [2:0] ICR_SRC_DIV2     = 3'h3;
  localparam logic [2:0] ICR_SRC_EXT      = 3'h4;
  localparam logic [2:0] ICR_DIV_5        = 3'h5;
  localparam logic [2:0] ICR_DIV_4        = 3'h4;
  localparam logic [2:0] ICR_DIV_3        = 3'h3;
  localparam logic [2:0] ICR_DIV_2        = 3'h2;
  // wait state bases
  localparam logic [2:0] ICR_WS16_BASE    = 3'h3;
  localparam logic [2:0] ICR_WS8_BASE     = 3'h5;

  // decoded expansion-bus timing
  typedef struct packed {
    logic [1:0] mem16_delay;
    logic [1:0] mem8_delay;
    logic [1:0] io_delay;
    logic [2:0] mem16_waits;
    logic [2:0] mem8_waits;
    logic       addr_hold;
  } icr_timing_s;

  // memory cycle from another bus master
  typedef struct packed {
    logic valid;
    logic write;
    logic hit;
  } icr_master_cycle_s;

  // data buffer direction
  typedef enum logic [1:0] {
    ICR_BUF_IDLE,
    ICR_BUF_READ,
    ICR_BUF_WRITE
  } icr_buf_dir_e;

  // controller actions for a bus-master memory cycle
  typedef struct packed {
    logic         cache_read;
    logic         cache_write;
    logic         dram_read;
    logic         dram_write;
    icr_buf_dir_e buf_dir;
  } icr_master_ctrl_s;
endpackage

// File: rtl/icr_clk_gen.sv
// bus clock source select and half-rate expansion output clock
module icr_clk_gen
  import icr_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // source selection
  input  wire logic [2:0] src_sel_i,
  input  wire logic       cpu_double_clock_input_i,
  input  wire logic       external_bus_oscillator_i,
  // output clock
  output logic            expansion_output_clock_o
);
  function automatic logic [2:0] div_of(input logic [2:0] sel);
    case (sel)
      ICR_SRC_DIV5: div_of = ICR_DIV_5;
      ICR_SRC_DIV4: div_of = ICR_DIV_4;
      ICR_SRC_DIV3: div_of = ICR_DIV_3;
      default:      div_of = ICR_DIV_2;
    endcase
  endfunction

  logic       dbl_q;
  logic       dbl_prev_q;
  logic       ext_q;
  logic       ext_prev_q;
  logic [2:0] cnt_q;
  logic       src_tick;
  logic       out_q;
  logic       cpu_rise;
  logic       ext_rise;

  // source inputs sampled on the system clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbl_q      <= 1'b0;
      dbl_prev_q <= 1'b0;
      ext_q      <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      dbl_q      <= cpu_double_clock_input_i;
      dbl_prev_q <= dbl_q;
      ext_q      <= external_bus_oscillator_i;
      ext_prev_q <= ext_q;
    end
  end

  assign cpu_rise = dbl_q & ~dbl_prev_q;
  assign ext_rise = ext_q & ~ext_prev_q;

  // divider of the doubled cpu clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 3'h0;
    end else if (cpu_rise) begin
      if (cnt_q >= div_of(src_sel_i) - 3'h1) begin
        cnt_q <= 3'h0;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  always_comb begin
    if (src_sel_i == ICR_SRC_EXT) begin
      src_tick = ext_rise;
    end else begin
      src_tick = cpu_rise && (cnt_q >= div_of(src_sel_i) - 3'h1);
    end
  end

  // half the selected source rate
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_q <= 1'b0;
    end else if (src_tick) begin
      out_q <= ~out_q;
    end
  end

  assign expansion_output_clock_o = out_q;
endmodule

// File: rtl/icr_top.sv
// indexed configuration register bank with bus-master cache steering
module icr_top
  import icr_pkg::*;
#(
  parameter logic [3:0] REV_LEVEL = 4'h1 // arbitrary value
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // configuration i/o cycle
  input  wire logic              config_select_n_i,
  input  wire logic [7:0]        io_addr_i,
  input  wire logic              io_rd_i,
  input  wire logic              io_wr_i,
  input  wire logic [7:0]        memory_address_lines_i,
  output logic      [7:0]        memory_address_lines_o,
  output logic                   memory_address_lines_oe_o,
  // bus-master memory cycle
  input  icr_master_cycle_s      master_cycle_i,
  output icr_master_ctrl_s       master_ctrl_o,
  // expansion-bus timing and direct port
  output icr_timing_s            timing_o,
  output logic      [7:0]        direct_port_o,
  // non-cacheable region setup
  output logic [ICR_NC_REGS*8-1:0] noncache_region_regs_o,
  // clocks
  input  wire logic              cpu_double_clock_input_i,
  input  wire logic              external_bus_oscillator_i,
  output logic                   expansion_output_clock_o
);
  logic [7:0] index_q;
  logic [7:0] cmd_dly_q;
  logic [7:0] wait_q;
  logic [7:0] clk_src_q;
  logic [7:0] port_en_q;
  logic [7:0] direct_q;
  logic [7:0] nc_q [ICR_NC_REGS];
  logic [7:0] rd_data_q;
  logic       rd_oe_q;
  logic       ports_on;
  logic       idx_wr;
  logic       dat_wr;
  logic       dat_rd;
  logic       dir_wr;
  logic       dir_rd;
  logic [7:0] rd_mux;
  logic [7:0] nc_off;

  function automatic logic is_nc(input logic [7:0] idx);
    is_nc = (idx >= ICR_IDX_NC_FIRST) && (idx <= ICR_IDX_NC_LAST);
  endfunction

  // select-qualified strobe aimed at one port
  function automatic logic port_hit(input logic       sel_n,
                                    input logic       strobe,
                                    input logic [7:0] addr,
                                    input logic [7:0] port);
    port_hit = !sel_n && strobe && (addr == port);
  endfunction

  // port decode qualified by config select
  assign ports_on = port_en_q[ICR_PORT_EN_BIT];
  assign idx_wr = ports_on
                  && port_hit(config_select_n_i, io_wr_i, io_addr_i, ICR_PORT_INDEX);
  assign dat_wr = ports_on
                  && port_hit(config_select_n_i, io_wr_i, io_addr_i, ICR_PORT_DATA);
  assign dat_rd = ports_on
                  && port_hit(config_select_n_i, io_rd_i, io_addr_i, ICR_PORT_DATA);
  assign dir_wr = port_hit(config_select_n_i, io_wr_i, io_addr_i, ICR_PORT_DIRECT);
  assign dir_rd = port_hit(config_select_n_i, io_rd_i, io_addr_i, ICR_PORT_DIRECT);
  assign nc_off = index_q - ICR_IDX_NC_FIRST;

  // index register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index_q <= 8'h00;
    end else if (idx_wr) begin
      index_q <= memory_address_lines_i;
    end
  end

  // expansion timing, clock source and port enable registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_dly_q <= ICR_RST_CMD_DLY;
      wait_q    <= ICR_RST_WAIT;
      clk_src_q <= ICR_RST_CLK_SRC;
      port_en_q <= ICR_RST_PORT_EN;
    end else if (dat_wr) begin
      if (index_q == ICR_IDX_CMD_DLY) begin
        cmd_dly_q <= memory_address_lines_i & ICR_MASK_CMD_DLY;
      end else if (index_q == ICR_IDX_WAIT) begin
        wait_q <= memory_address_lines_i & ICR_MASK_WAIT;
      end else if (index_q == ICR_IDX_CLK_SRC) begin
        clk_src_q <= memory_address_lines_i & ICR_MASK_CLK_SRC;
      end else if (index_q == ICR_IDX_PORT_EN) begin
        port_en_q <= memory_address_lines_i;
      end
    end
  end

  // non-cacheable region registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < ICR_NC_REGS; i++) begin
        nc_q[i] <= 8'h00;
      end
    end else if (dat_wr && is_nc(index_q)) begin
      nc_q[nc_off[3:0]] <= memory_address_lines_i;
    end
  end

  // direct port
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      direct_q <= ICR_RST_DIRECT;
    end else if (dir_wr) begin
      direct_q <= memory_address_lines_i;
    end
  end

  // read selection
  always_comb begin
    rd_mux = 8'h00;
    if (dir_rd) begin
      rd_mux = direct_q;
    end else if (index_q == ICR_IDX_REV) begin
      rd_mux = {4'h0, REV_LEVEL} & ICR_MASK_REV;
    end else if (index_q == ICR_IDX_CMD_DLY) begin
      rd_mux = cmd_dly_q;
    end else if (index_q == ICR_IDX_WAIT) begin
      rd_mux = wait_q;
    end else if (index_q == ICR_IDX_CLK_SRC) begin
      rd_mux = clk_src_q;
    end else if (index_q == ICR_IDX_PORT_EN) begin
      rd_mux = port_en_q;
    end else if (is_nc(index_q)) begin
      rd_mux = nc_q[nc_off[3:0]];
    end
  end

  // read data held on the address lines one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_q <= 8'h00;
      rd_oe_q   <= 1'b0;
    end else begin
      rd_oe_q <= dat_rd || dir_rd;
      if (dat_rd || dir_rd) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  assign memory_address_lines_o    = rd_data_q;
  assign memory_address_lines_oe_o = rd_oe_q && !config_select_n_i;
  assign direct_port_o             = direct_q;

  always_comb begin
    for (int i = 0; i < ICR_NC_REGS; i++) begin
      noncache_region_regs_o[i*8 +: 8] = nc_q[i];
    end
  end

  // timing decode
  always_comb begin
    timing_o.mem16_delay = cmd_dly_q[ICR_M16_LSB +: 2];
    timing_o.mem8_delay  = cmd_dly_q[ICR_M8_LSB +: 2];
    timing_o.io_delay    = cmd_dly_q[ICR_IO_LSB +: 2];
    timing_o.mem16_waits = ICR_WS16_BASE - {1'b0, wait_q[ICR_M16_LSB +: 2]};
    timing_o.mem8_waits  = ICR_WS8_BASE - {1'b0, wait_q[ICR_M8_LSB +: 2]};
    timing_o.addr_hold   = wait_q[ICR_HOLD_BIT];
  end

  // bus-master memory cycle steering
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_ctrl_o <= '{1'b0, 1'b0, 1'b0, 1'b0, ICR_BUF_IDLE};
    end else if (!master_cycle_i.valid) begin
      master_ctrl_o <= '{1'b0, 1'b0, 1'b0, 1'b0, ICR_BUF_IDLE};
    end else if (!master_cycle_i.write) begin
      master_ctrl_o.cache_read  <= 1'b0;
      master_ctrl_o.cache_write <= 1'b0;
      master_ctrl_o.dram_read   <= 1'b1;
      master_ctrl_o.dram_write  <= 1'b0;
      master_ctrl_o.buf_dir     <= ICR_BUF_READ;
    end else begin
      master_ctrl_o.cache_read  <= 1'b0;
      master_ctrl_o.cache_write <= master_cycle_i.hit;
      master_ctrl_o.dram_read   <= 1'b0;
      master_ctrl_o.dram_write  <= 1'b1;
      master_ctrl_o.buf_dir     <= ICR_BUF_WRITE;
    end
  end

  icr_clk_gen u_clk_gen (
    .clk_i                     (clk_i),
    .rst_n_i                   (rst_n_i),
    .src_sel_i                 (clk_src_q[ICR_SRC_LSB +: 3]),
    .cpu_double_clock_input_i  (cpu_double_clock_input_i),
    .external_bus_oscillator_i (external_bus_oscillator_i),
    .expansion_output_clock_o  (expansion_output_clock_o)
  );
endmodule

// File: test/icr_asserts.sv
// assertion checker for the configuration register bank
module icr_asserts
  import icr_pkg::*;
(
  // clock and reset
  input wire logic         clk_i,
  input wire logic         rst_n_i,
  // i/o cycle
  input wire logic         config_select_n_i,
  input wire logic [7:0]   io_addr_i,
  input wire logic         io_rd_i,
  input wire logic         io_wr_i,
  input wire logic [7:0]   memory_address_lines_i,
  input wire logic         memory_address_lines_oe_o,
  input wire logic [7:0]   direct_port_o,
  // master cycle and timing
  input icr_master_cycle_s master_cycle_i,
  input icr_master_ctrl_s  master_ctrl_o,
  input icr_timing_s       timing_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic sel, mrd, mwr, p92, pdat, pok;
  assign sel  = !config_select_n_i;
  assign mrd  = master_cycle_i.valid && !master_cycle_i.write;
  assign mwr  = master_cycle_i.valid && master_cycle_i.write;
  assign p92  = io_addr_i == ICR_PORT_DIRECT;
  assign pdat = sel && io_wr_i && io_addr_i == ICR_PORT_DATA;
  assign pok  = p92 || io_addr_i == ICR_PORT_DATA || io_addr_i == ICR_PORT_INDEX;
  chk_master_rd: assert property (mrd |=> master_ctrl_o.dram_read &&
    !master_ctrl_o.cache_read && !master_ctrl_o.cache_write &&
    master_ctrl_o.buf_dir == ICR_BUF_READ) else $error("master read");
  chk_master_wr: assert property (mwr |=> master_ctrl_o.dram_write &&
    master_ctrl_o.buf_dir == ICR_BUF_WRITE && !master_ctrl_o.cache_read &&
    master_ctrl_o.cache_write == $past(master_cycle_i.hit)) else $error("master write");
  chk_direct_rd: assert property (sel && io_rd_i && p92 ##1 sel |->
    memory_address_lines_oe_o) else $error("no read answer");
  chk_oe_cause: assert property (memory_address_lines_oe_o |->
    sel && $past(io_rd_i)) else $error("stray drive");
  chk_bad_port: assert property (sel && io_rd_i && !pok |=>
    !memory_address_lines_oe_o) else $error("odd port answered");
  chk_direct_wr: assert property (sel && io_wr_i && p92 |=>
    direct_port_o == $past(memory_address_lines_i)) else $error("direct write");
  chk_timing_hold: assert property (!pdat |=> $stable(timing_o))
    else $error("timing moved");
  chk_wait_range: assert property (timing_o.mem16_waits <= 3'h3 &&
    timing_o.mem8_waits >= 3'h2 && timing_o.mem8_waits <= 3'h5) else $error("wait range");
  cover property (mrd);
  cover property (mwr && master_cycle_i.hit);
  cover property (memory_address_lines_oe_o);
endmodule

bind icr_top icr_asserts icr_asserts_inst (.clk_i, .rst_n_i, .config_select_n_i, .io_addr_i,
  .io_rd_i, .io_wr_i, .memory_address_lines_i, .memory_address_lines_oe_o, .direct_port_o,
  .master_cycle_i, .master_ctrl_o, .timing_o);

// File: test/icr_host_model.sv
// host model issuing i/o port cycles
module icr_host_model
  import icr_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // i/o cycle
  output logic            cs_n_o,
  output logic [7:0]      addr_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic [7:0]      data_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cs_n_o, rd_o, wr_o} = 3'h4;
    {addr_o, data_o} = 16'h0000;
  end
  // released lines show the inverse of the last value
  task automatic idle();
    cs_n_o = 1'b1;
    addr_o = ~addr_o;
    data_o = ~data_o;
  endtask
  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) #2 cs_n_o = 1'b0;
    {addr_o, data_o, wr_o} = {a, d, 1'b1};
    @(posedge clk_i) #2 wr_o = 1'b0;
    idle();
  endtask
  task automatic io_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_i) #2 cs_n_o = 1'b0;
    {addr_o, rd_o} = {a, 1'b1};
    @(posedge clk_i) #2 rd_o = 1'b0;
    {d, ok} = {rdata_i, oe_i};
    @(posedge clk_i) #2 idle();
  endtask
  task automatic reg_write(input logic [7:0] i, input logic [7:0] d);
    io_write(ICR_PORT_INDEX, i);
    io_write(ICR_PORT_DATA, d);
  endtask
  task automatic reg_read(input logic [7:0] i, output logic [7:0] d, output logic ok);
    io_write(ICR_PORT_INDEX, i);
    io_read(ICR_PORT_DATA, d, ok);
  endtask
endmodule

// File: test/tb.sv
// self-checking bench for the configuration register bank
module tb
  import icr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_i = 0, rst_n_i = 0, cs_n, rd, wr, oe, cc = 0, xc = 0, bclk;
  logic [7:0]        addr, wd, rdat, mal, dir, d;
  logic              ok;
  logic [79:0]       nc;
  icr_master_cycle_s mc = '0;
  icr_master_ctrl_s  ctl;
  icr_timing_s       tm;
  int                n_fail = 0, checked = 0, cyc = 0, n;
  assign mal = oe ? rdat : wd;
  initial forever #10 clk_i = ~clk_i;
  initial #5 forever #50 cc = ~cc;
  initial #5 forever #80 xc = ~xc;
  icr_top #(.REV_LEVEL(4'h9)) icr_top_inst (.clk_i, .rst_n_i, .config_select_n_i(cs_n),
    .io_addr_i(addr), .io_rd_i(rd), .io_wr_i(wr), .memory_address_lines_i(mal),
    .memory_address_lines_o(rdat), .memory_address_lines_oe_o(oe), .master_cycle_i(mc),
    .master_ctrl_o(ctl), .timing_o(tm), .direct_port_o(dir), .noncache_region_regs_o(nc),
    .cpu_double_clock_input_i(cc), .external_bus_oscillator_i(xc),
    .expansion_output_clock_o(bclk));
  icr_host_model icr_host_model_inst (.clk_i, .cs_n_o(cs_n), .addr_o(addr), .rd_o(rd),
    .wr_o(wr), .data_o(wd), .rdata_i(mal), .oe_i(oe));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic wrg(input logic [7:0] i, input logic [7:0] v);
    icr_host_model_inst.reg_write(i, v);
  endtask
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    icr_host_model_inst.reg_read(i, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, e);
  endtask
  // cycles from the call up to the next rise of the expansion clock
  task automatic rise(output int k);
    logic p;
    {k, p} = {32'h0, 1'b1};
    while (k < 200) begin
      @(posedge clk_i) #1 k++;
      if (bclk === 1'b1 && p === 1'b0) break;
      p = bclk;
    end
  endtask
  task automatic t_reset();
    rc(ICR_IDX_REV, 8'h09);
    wrg(ICR_IDX_REV, 8'hff);
    rc(ICR_IDX_REV, 8'h09);
    rc(ICR_IDX_CMD_DLY, 8'h00);
    rc(8'h08, 8'h00);
    chk({2'h0, tm.mem16_waits, tm.mem8_waits}, 8'h1d);
  endtask
  task automatic t_fields();
    logic [1:0] a, b, e;
    for (int c = 0; c < 4; c++) begin
      {a, b, e} = {c[1:0], c[1:0] + 2'h1, ~c[1:0]};
      wrg(ICR_IDX_CMD_DLY, {2'h3, a, b, e});
      rc(ICR_IDX_CMD_DLY, {2'h0, a, b, e});
      chk({2'h0, tm.mem16_delay, tm.mem8_delay, tm.io_delay}, {2'h0, a, b, e});
      wrg(ICR_IDX_WAIT, {2'h3, a, b, a[0], 1'b1});
      rc(ICR_IDX_WAIT, {2'h0, a, b, a[0], 1'b0});
      chk({1'h0, tm.mem16_waits, tm.mem8_waits, tm.addr_hold},
          {1'h0, 3'h3 - {1'b0, a}, 3'h5 - {1'b0, b}, a[0]});
    end
  endtask
  task automatic t_clk();
    for (int c = 0; c < 5; c++) begin
      wrg(ICR_IDX_CLK_SRC, 8'hf8 | c[7:0]);
      rc(ICR_IDX_CLK_SRC, c[7:0]);
      rise(n);
      rise(n);
      chk(n[7:0], (c == 4) ? 8'h10 : 8'h0a * (8'h05 - c[7:0]));
    end
  endtask
  task automatic t_master();
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_i) #2 mc = {1'b1, c[1], c[0]};
      @(posedge clk_i) #2 chk({2'h0, ctl}, {2'h0, 1'b0, c[1] & c[0], !c[1], c[1],
          c[1] ? ICR_BUF_WRITE : ICR_BUF_READ});
    end
    mc = '0;
  endtask
  task automatic t_direct();
    icr_host_model_inst.io_write(ICR_PORT_DIRECT, 8'ha5);
    chk(dir, 8'ha5);
    icr_host_model_inst.io_read(8'h24, d, ok);
    chk({7'h00, ok}, 8'h00);
    wrg(ICR_IDX_NC_FIRST, 8'h5a);
    wrg(ICR_IDX_NC_LAST, 8'hc3);
    chk(nc[7:0], 8'h5a);
    chk(nc[79:72], 8'hc3);
    rc(ICR_IDX_NC_FIRST, 8'h5a);
    rc(ICR_IDX_NC_LAST, 8'hc3);
    wrg(ICR_IDX_PORT_EN, 8'h00);
    wrg(ICR_IDX_WAIT, 8'h00);
    icr_host_model_inst.reg_read(ICR_IDX_WAIT, d, ok);
    chk({ok, tm.mem16_waits}, 8'h00);
    icr_host_model_inst.io_read(ICR_PORT_DIRECT, d, ok);
    chk(d, 8'ha5);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    #2 rst_n_i = 1'b1;
    t_reset();
    t_fields();
    t_clk();
    t_master();
    t_direct();
    rst_n_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #2 rst_n_i = 1'b1;
    rc(ICR_IDX_PORT_EN, 8'h40);
    end_of_test();
  end
endmodule
